// file: token_net_seq.sv
// transmit/receive sequencer of a token-passing network node, with APB registers
`timescale 1ns/1ps
`include "pkt_seq_consts.svh"
module token_net_seq #(
  parameter int BUF_BYTES = 2048,
  parameter logic [7:0] NAK_LIMIT_RST = 8'h80
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic token_in,
  output logic token_pass,
  output logic fbe_req,
  output logic [7:0] fbe_dest,
  input wire pkt_seq_pkg::reply_beat_t reply_in,
  output pkt_seq_pkg::byte_beat_t tx_out,
  input wire logic tx_ready,
  input wire logic fbe_in,
  output logic fbe_ans_valid,
  output logic fbe_ans_ack,
  input wire pkt_seq_pkg::byte_beat_t rx_in,
  input wire logic rx_err
);
  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  // address arithmetic is 11 bits wide, so only a 2048-byte buffer is served
  if (BUF_BYTES != 2048) begin : g_chk
    $error("BUF_BYTES must be 2048");
  end
  // ----------------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------------
  logic [7:0] ram_q [0:2047];
  logic ram_we;
  logic [10:0] ram_wa;
  logic [7:0] ram_wd;
  logic ta_q, ta_d, tma_q, tma_d, ri_q, ri_d, exc_q, exc_d;
  logic [2:0] mask_q, mask_d;
  logic [7:0] node_q, node_d, nlim_q, nlim_d, nak_q, nak_d;
  logic long_en_q, long_en_d;
  logic [15:0] ptr_q, ptr_d;
  logic [31:0] prdata_q, prdata_d;
  logic irq_q, irq_d;
  pkt_seq_pkg::tx_state_t st_q, st_d;
  logic pend_q, pend_d, cancel_q, cancel_d, bcast_q, bcast_d, tlong_q, tlong_d;
  logic [10:0] tbase_q, tbase_d, rbase_q, rbase_d;
  logic [9:0] tpos_q, tpos_d, rpos_q, rpos_d;
  logic [7:0] tcnt_q, tcnt_d;
  pkt_seq_pkg::byte_beat_t tx_q, tx_d;
  logic pass_q, pass_d, fbe_q, fbe_d, ansv_q, ansv_d, ansa_q, ansa_d;
  logic [7:0] dest_q, dest_d;
  logic rhdr_q, rhdr_d, rok_q, rok_d;
  // bus decode
  logic setup, acc, wr, mapped, buf_acc, host_we, rx_we, tx_we;
  logic [2:0] code;
  logic [10:0] page_base, tx_addr;
  logic [9:0] seg_len;
  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // reads are latched in the setup cycle; a buffer write waits while the
  // receiver owns the single write port
  always_comb begin
    setup = psel & ~penable;
    mapped = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'h0);
    buf_acc = paddr[7:0] == `OFS_BUF_DATA;
    pready = ~(psel & penable & pwrite & buf_acc & rx_we);
    acc = psel & penable & pready;
    wr = acc & pwrite;
    host_we = wr & buf_acc & mapped;
    code = pwdata[`CMD_CODE_MSB:0];
    // start of the named page plus optional half-page offset
    page_base = (11'(pwdata[`CMD_PAGE_LSB+1:`CMD_PAGE_LSB]) * `PAGE_BYTES)
      + (pwdata[`CMD_OFFSET_BIT] ? `HALF_PAGE : 11'h000);
    seg_len = tlong_q ? `LONG_SEG : `SHORT_SEG;
    tx_addr = 11'(tbase_q + 11'(tpos_q));
  end
  // register read mux, captured at setup
  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      unique case (paddr[7:0])
        `OFS_STATUS: prdata_d = 32'(({exc_q, ri_q, tma_q, ta_q}));
        `OFS_MASK: prdata_d = 32'(mask_q);
        `OFS_NODE_ID: prdata_d = 32'(node_q);
        `OFS_BUF_PTR: prdata_d = 32'(ptr_q);
        `OFS_BUF_DATA: prdata_d = 32'(ram_q[ptr_q[10:0]]);
        `OFS_DIAG: prdata_d = 32'({nak_q, 7'h00, exc_q});
        `OFS_NAK_LIMIT: prdata_d = 32'(nlim_q);
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // host-owned registers
  // ----------------------------------------------------------------------
  always_comb begin
    mask_d = mask_q;
    node_d = node_q;
    nlim_d = nlim_q;
    ptr_d = ptr_q;
    long_en_d = long_en_q;
    if (wr && mapped) begin
      unique case (paddr[7:0])
        `OFS_MASK: mask_d = pwdata[2:0];
        `OFS_NODE_ID: node_d = pwdata[7:0];
        `OFS_NAK_LIMIT: nlim_d = pwdata[7:0];
        `OFS_BUF_PTR: ptr_d = {pwdata[`PTR_AUTOINC_BIT], 4'h0, pwdata[10:0]};
        `OFS_CMD: if (code == `CMD_DEF_CFG) long_en_d = pwdata[`CMD_LONG_BIT];
        default: ;
      endcase
    end
    // auto increment after each completed data access, wrapping in the buffer
    if (acc && mapped && buf_acc && ptr_q[`PTR_AUTOINC_BIT]) begin
      ptr_d = {ptr_q[15:11], 11'(ptr_q[10:0] + 11'h001)};
    end
    // flags combined onto one level; status bits are levels, not events
    irq_d = |(mask_q & {exc_q, ri_q, ta_q});
  end
  // ----------------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    ta_d = ta_q;
    tma_d = tma_q;
    exc_d = exc_q;
    nak_d = nak_q;
    pend_d = pend_q;
    cancel_d = cancel_q;
    bcast_d = bcast_q;
    tlong_d = tlong_q;
    tbase_d = tbase_q;
    tpos_d = tpos_q;
    tcnt_d = tcnt_q;
    tx_d = tx_q;
    dest_d = dest_q;
    pass_d = 1'b0;
    fbe_d = 1'b0;
    tx_we = 1'b0;
    // software clears the excessive-NAK flag by writing one
    if (wr && mapped && paddr[7:0] == `OFS_DIAG && pwdata[0]) exc_d = 1'b0;
    if (wr && mapped && paddr[7:0] == `OFS_CMD) begin
      // a new transmit is only taken while the transmitter is free
      if (code == `CMD_EN_TX && ta_q && st_q == pkt_seq_pkg::TX_IDLE) begin
        ta_d = 1'b0;
        tma_d = 1'b0;
        pend_d = 1'b1;
        cancel_d = 1'b0;
        nak_d = 8'h00;
        tbase_d = page_base;
      end
      if (code == `CMD_DIS_TX && pend_q) cancel_d = 1'b1;
    end
    unique case (st_q)
      pkt_seq_pkg::TX_IDLE: begin
        if (pend_q && token_in) begin
          if (cancel_q) begin
            ta_d = 1'b1;
            pend_d = 1'b0;
            cancel_d = 1'b0;
            pass_d = 1'b1;
          end else begin
            st_d = pkt_seq_pkg::TX_SID;
          end
        end
      end
      pkt_seq_pkg::TX_SID: begin
        // the write port may be busy with receive or host data
        if (!rx_we && !host_we) begin
          tx_we = 1'b1;
          dest_d = ram_q[11'(tbase_q + 11'(`POS_DID))];
          tlong_d = long_en_q && ram_q[11'(tbase_q + 11'(`POS_COUNT))] == 8'h00;
          tcnt_d = tlong_d ? ram_q[11'(tbase_q + 11'(`POS_LCOUNT))]
            : ram_q[11'(tbase_q + 11'(`POS_COUNT))];
          bcast_d = dest_d == `BROADCAST_ID;
          tpos_d = `POS_SID;
          tx_d = '0;
          if (bcast_d) begin
            st_d = pkt_seq_pkg::TX_SEND;
          end else begin
            fbe_d = 1'b1;
            st_d = pkt_seq_pkg::TX_FBE;
          end
        end
      end
      pkt_seq_pkg::TX_FBE: begin
        if (reply_in.valid) begin
          unique case (reply_in.kind)
            pkt_seq_pkg::REPLY_ACK: st_d = pkt_seq_pkg::TX_SEND;
            pkt_seq_pkg::REPLY_NAK: begin
              // keep the command pending; next token enquires again
              pass_d = 1'b1;
              st_d = pkt_seq_pkg::TX_IDLE;
              nak_d = (nak_q == 8'hFF) ? nak_q : 8'(nak_q + 8'h01);
              if (nak_d >= nlim_q) exc_d = 1'b1;
            end
            pkt_seq_pkg::REPLY_NONE: begin
              ta_d = 1'b1;
              pend_d = 1'b0;
              pass_d = 1'b1;
              st_d = pkt_seq_pkg::TX_IDLE;
            end
            pkt_seq_pkg::REPLY_NOISE: begin
              // token held back; the lost-token timer elsewhere recovers
              st_d = pkt_seq_pkg::TX_IDLE;
            end
          endcase
        end
      end
      pkt_seq_pkg::TX_SEND: begin
        if (tx_q.valid && tx_ready && tx_q.last) begin
          tx_d.valid = 1'b0;
          if (bcast_q) begin
            ta_d = 1'b1;
            pend_d = 1'b0;
            pass_d = 1'b1;
            st_d = pkt_seq_pkg::TX_IDLE;
          end else begin
            st_d = pkt_seq_pkg::TX_ACKW;
          end
        end else if (!tx_q.valid || tx_ready) begin
          // header bytes, then data from the count position to segment end
          tx_d.valid = 1'b1;
          tx_d.data = (tpos_q == `POS_SID) ? node_q : ram_q[tx_addr];
          tx_d.last = tpos_q == 10'(seg_len - 10'h001);
          if (tpos_q == `POS_COUNT && !tlong_q) tpos_d = 10'(tcnt_q);
          else if (tpos_q == `POS_LCOUNT && tlong_q) tpos_d = 10'(tcnt_q);
          else tpos_d = 10'(tpos_q + 10'h001);
        end
      end
      pkt_seq_pkg::TX_ACKW: begin
        if (reply_in.valid) begin
          ta_d = 1'b1;
          tma_d = reply_in.kind == pkt_seq_pkg::REPLY_ACK;
          pend_d = 1'b0;
          pass_d = 1'b1;
          st_d = pkt_seq_pkg::TX_IDLE;
        end
      end
    endcase
    // a new NAK beats a same-cycle software clear
    if (st_q == pkt_seq_pkg::TX_FBE && reply_in.valid
        && reply_in.kind == pkt_seq_pkg::REPLY_NAK && nak_d >= nlim_q) begin
      exc_d = 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    ri_d = ri_q;
    rbase_d = rbase_q;
    rpos_d = rpos_q;
    rhdr_d = rhdr_q;
    rok_d = rok_q;
    ansv_d = fbe_in;
    ansa_d = fbe_in ? ~ri_q : ansa_q;
    rx_we = rx_in.valid && !ri_q;
    if (rx_we) begin
      // header fields land in place, data from the count position onward
      rpos_d = 10'(rpos_q + 10'h001);
      if (rhdr_q && rpos_q == `POS_COUNT) begin
        if (long_en_q && rx_in.data == 8'h00) begin
          rpos_d = `POS_LCOUNT;
        end else begin
          rhdr_d = 1'b0;
          rpos_d = 10'(rx_in.data);
        end
      end else if (rhdr_q && rpos_q == `POS_LCOUNT) begin
        rhdr_d = 1'b0;
        rpos_d = 10'(rx_in.data);
      end
      if (rx_in.last) begin
        ri_d = ~rx_err;
        rpos_d = `POS_SID;
        rhdr_d = 1'b1;
      end
    end
    if (wr && mapped && paddr[7:0] == `OFS_CMD && code == `CMD_EN_RX) begin
      ri_d = 1'b0;
      rbase_d = page_base;
      rpos_d = `POS_SID;
      rhdr_d = 1'b1;
    end
    rok_d = ri_d;
  end
  // single write port: receive first, then host data, then source id
  always_comb begin
    ram_we = rx_we | host_we | tx_we;
    ram_wa = tbase_q;
    ram_wd = node_q;
    if (rx_we) begin
      ram_wa = 11'(rbase_q + 11'(rpos_q));
      ram_wd = rx_in.data;
    end else if (host_we) begin
      ram_wa = ptr_q[10:0];
      ram_wd = pwdata[7:0];
    end
  end
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (ram_we) ram_q[ram_wa] <= ram_wd;
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ta_q <= `RST_TA;
      tma_q <= 1'b0;
      ri_q <= `RST_RI;
      exc_q <= 1'b0;
      mask_q <= `RST_MASK;
      node_q <= `RST_NODE_ID;
      nlim_q <= NAK_LIMIT_RST;
      nak_q <= 8'h00;
      long_en_q <= 1'b0;
      ptr_q <= 16'h0000;
      prdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      st_q <= pkt_seq_pkg::TX_IDLE;
      pend_q <= 1'b0;
      cancel_q <= 1'b0;
      bcast_q <= 1'b0;
      tlong_q <= 1'b0;
      tbase_q <= 11'h000;
      rbase_q <= 11'h000;
      tpos_q <= 10'h000;
      rpos_q <= 10'h000;
      tcnt_q <= 8'h00;
      tx_q <= '0;
      pass_q <= 1'b0;
      fbe_q <= 1'b0;
      dest_q <= 8'h00;
      ansv_q <= 1'b0;
      ansa_q <= 1'b0;
      rhdr_q <= 1'b1;
      rok_q <= `RST_RI;
    end else begin
      ta_q <= ta_d;
      tma_q <= tma_d;
      ri_q <= ri_d;
      exc_q <= exc_d;
      mask_q <= mask_d;
      node_q <= node_d;
      nlim_q <= nlim_d;
      nak_q <= nak_d;
      long_en_q <= long_en_d;
      ptr_q <= ptr_d;
      prdata_q <= prdata_d;
      irq_q <= irq_d;
      st_q <= st_d;
      pend_q <= pend_d;
      cancel_q <= cancel_d;
      bcast_q <= bcast_d;
      tlong_q <= tlong_d;
      tbase_q <= tbase_d;
      rbase_q <= rbase_d;
      tpos_q <= tpos_d;
      rpos_q <= rpos_d;
      tcnt_q <= tcnt_d;
      tx_q <= tx_d;
      pass_q <= pass_d;
      fbe_q <= fbe_d;
      dest_q <= dest_d;
      ansv_q <= ansv_d;
      ansa_q <= ansa_d;
      rhdr_q <= rhdr_d;
      rok_q <= rok_d;
    end
  end
  // outputs
  assign prdata = prdata_q;
  assign pslverr = psel & penable & ~mapped;
  assign irq = irq_q;
  assign token_pass = pass_q;
  assign fbe_req = fbe_q;
  assign fbe_dest = dest_q;
  assign tx_out = tx_q;
  assign fbe_ans_valid = ansv_q;
  assign fbe_ans_ack = ansa_q;
endmodule

// file: pkt_seq_consts.svh
// offsets, field positions, reset values and counts of the packet sequencer
`ifndef PKT_SEQ_CONSTS_SVH
`define PKT_SEQ_CONSTS_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_STATUS 8'h00
`define OFS_MASK 8'h04
`define OFS_CMD 8'h08
`define OFS_NODE_ID 8'h0C
`define OFS_BUF_PTR 8'h10
`define OFS_BUF_DATA 8'h14
`define OFS_DIAG 8'h18
`define OFS_NAK_LIMIT 8'h1C
// ----------------------------------------------------------------------
// command word fields and codes
// ----------------------------------------------------------------------
`define CMD_CODE_MSB 2
`define CMD_PAGE_LSB 3
`define CMD_OFFSET_BIT 5
`define CMD_LONG_BIT 3
`define CMD_DIS_TX 3'h1
`define CMD_EN_TX 3'h3
`define CMD_EN_RX 3'h4
`define CMD_DEF_CFG 3'h5
// ----------------------------------------------------------------------
// status bit positions, pointer auto-increment bit and reset values
// ----------------------------------------------------------------------
`define ST_TA 0
`define ST_TMA 1
`define ST_RI 2
`define ST_EXCESSIVE_NAK_FLAG 3
`define PTR_AUTOINC_BIT 15
`define RST_TA 1'b1
`define RST_RI 1'b1
`define RST_MASK 3'h0
`define RST_NODE_ID 8'h00
// ----------------------------------------------------------------------
// packet layout
// ----------------------------------------------------------------------
`define SHORT_SEG 10'h100
`define LONG_SEG 10'h200
`define PAGE_BYTES 11'h200
`define HALF_PAGE 11'h100
`define POS_SID 10'h000
`define POS_DID 10'h001
`define POS_COUNT 10'h002
`define POS_LCOUNT 10'h003
`define BROADCAST_ID 8'h00
`endif

// file: pkt_seq_pkg.sv
// types shared by the packet sequencer and its link partner logic
package pkt_seq_pkg;
  typedef enum logic [1:0] {
    REPLY_ACK = 2'h0,
    REPLY_NAK = 2'h1,
    REPLY_NONE = 2'h2,
    REPLY_NOISE = 2'h3
  } reply_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } byte_beat_t;
  typedef struct packed {
    logic valid;
    reply_t kind;
  } reply_beat_t;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_SID = 5'h02,
    TX_FBE = 5'h04,
    TX_SEND = 5'h08,
    TX_ACKW = 5'h10
  } tx_state_t;
endpackage

// file: token_net_seq_monitor.sv
// assertion checker for the link side of the packet sequencer
`timescale 1ns/1ps
module token_net_seq_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic token_in,
  input wire logic token_pass,
  input wire logic fbe_req,
  input wire pkt_seq_pkg::reply_beat_t reply_in,
  input wire pkt_seq_pkg::byte_beat_t tx_out,
  input wire logic tx_ready,
  input wire logic fbe_in,
  input wire logic fbe_ans_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic enq_q, enq_d;
  // open from enquiry until its reply, so packet replies are not taken as enquiry replies
  always_comb begin
    enq_d = enq_q;
    if (reply_in.valid) enq_d = 1'b0;
    if (fbe_req) enq_d = 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (!rstn) enq_q <= 1'b0;
    else enq_q <= enq_d;
  end
  enq_answer_a: assert property (fbe_in |=> fbe_ans_valid)
    else $error("enquiry not answered");
  enq_token_a: assert property (fbe_req |-> $past(token_in, 2))
    else $error("enquiry without token");
  tok_pulse_a: assert property (token_pass |=> !token_pass)
    else $error("token pass longer than one cycle");
  tx_hold_a: assert property (tx_out.valid && !tx_ready |=>
    tx_out.valid && $stable(tx_out.data) && $stable(tx_out.last))
    else $error("tx byte changed while stalled");
  noise_keep_a: assert property (enq_q && reply_in.valid &&
    reply_in.kind == pkt_seq_pkg::REPLY_NOISE |=> (!token_pass) [*4])
    else $error("token passed after noise");
  nak_pass_a: assert property (enq_q && reply_in.valid &&
    reply_in.kind == pkt_seq_pkg::REPLY_NAK |-> ##[1:3] token_pass)
    else $error("token not passed after nak");
  ack_send_a: assert property (enq_q && reply_in.valid &&
    reply_in.kind == pkt_seq_pkg::REPLY_ACK |-> ##[1:4] tx_out.valid)
    else $error("packet not sent after ack");
  last_end_a: assert property (tx_out.valid && tx_out.last && tx_ready |=> !tx_out.valid)
    else $error("stream runs past last byte");
endmodule
bind token_net_seq token_net_seq_monitor mon (.mclk(mclk), .rstn(rstn), .token_in(token_in),
  .token_pass(token_pass), .fbe_req(fbe_req), .reply_in(reply_in), .tx_out(tx_out),
  .tx_ready(tx_ready), .fbe_in(fbe_in), .fbe_ans_valid(fbe_ans_valid));

// file: far_node.sv
// far-side node model: answers enquiries and packets, sinks bytes with stalls
`timescale 1ns/1ps
module far_node (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic fbe_req,
  input wire pkt_seq_pkg::byte_beat_t tx_out,
  input wire pkt_seq_pkg::reply_t enq_kind,
  input wire pkt_seq_pkg::reply_t pkt_kind,
  output pkt_seq_pkg::reply_beat_t reply_in,
  output logic tx_ready
);
  logic [7:0] got [$];
  logic [2:0] lag = 3'h0;
  logic [1:0] beat = 2'h0;
  initial reply_in = '0;
  initial tx_ready = 1'b0;
  // enquiry reply three cycles late; sink refuses every fourth cycle
  always @(posedge mclk) begin
    reply_in <= '0;
    beat <= beat + 2'h1;
    tx_ready <= rstn && beat != 2'h0;
    lag <= rstn ? {lag[1:0], fbe_req} : 3'h0;
    if (lag[2]) reply_in <= '{1'b1, enq_kind};
    if (tx_out.valid && tx_ready) begin
      got.push_back(tx_out.data);
      if (tx_out.last) reply_in <= '{1'b1, pkt_kind};
    end
  end
endmodule

// file: token_net_packet_tx_rx_sequencer_test.sv
// self-checking bench for the packet sequencer
`timescale 1ns/1ps
`include "pkt_seq_consts.svh"
module token_net_packet_tx_rx_sequencer_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, token_pass, fbe_req, fbe_ans_valid, fbe_ans_ack, ok, err;
  logic token_in = 1'b0, fbe_in = 1'b0, rx_err = 1'b0, tx_ready;
  logic [7:0] fbe_dest;
  logic [7:0] exp_q [$];
  logic [7:0] pk [$];
  pkt_seq_pkg::reply_beat_t reply_in;
  pkt_seq_pkg::byte_beat_t tx_out;
  pkt_seq_pkg::byte_beat_t rx_in = '0;
  pkt_seq_pkg::reply_t enq_kind = pkt_seq_pkg::REPLY_ACK, pkt_kind = pkt_seq_pkg::REPLY_ACK;
  int fail_count = 0, n_compared = 0;
  always #5 mclk = ~mclk;
  token_net_seq #(.NAK_LIMIT_RST(8'h02)) DUT (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .token_in(token_in),
    .token_pass(token_pass), .fbe_req(fbe_req), .fbe_dest(fbe_dest), .reply_in(reply_in),
    .tx_out(tx_out), .tx_ready(tx_ready), .fbe_in(fbe_in), .fbe_ans_valid(fbe_ans_valid),
    .fbe_ans_ack(fbe_ans_ack), .rx_in(rx_in), .rx_err(rx_err));
  far_node PEER (.mclk(mclk), .rstn(rstn), .fbe_req(fbe_req), .tx_out(tx_out),
    .enq_kind(enq_kind), .pkt_kind(pkt_kind), .reply_in(reply_in), .tx_ready(tx_ready));
  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb transfer; waits on pready, bounded so a stuck slave cannot hang the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) cmp(32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  task automatic fill(input logic [10:0] at, input logic [7:0] b [$]);
    wr(`OFS_BUF_PTR, {16'h0, 1'b1, 4'h0, at});
    foreach (b[i]) wr(`OFS_BUF_DATA, {24'h0, b[i]});
  endtask
  task automatic peek(input logic [10:0] at, input logic [7:0] e);
    wr(`OFS_BUF_PTR, {21'h0, at});
    chk(`OFS_BUF_DATA, {24'h0, e});
  endtask
  // hand the token over and wait, bounded, for it to come back
  task automatic tok(input int lim);
    int n;
    n = 0;
    @(posedge mclk);
    token_in <= 1'b1;
    @(posedge mclk);
    token_in <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (token_pass !== 1'b1 && n < lim);
    ok = token_pass;
  endtask
  task automatic got_chk;
    cmp(32'(PEER.got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) cmp({24'h0, PEER.got[i]}, {24'h0, exp_q[i]});
    PEER.got.delete();
  endtask
  task automatic enq(input logic e);
    @(posedge mclk);
    fbe_in <= 1'b1;
    @(posedge mclk);
    fbe_in <= 1'b0;
    @(posedge mclk);
    cmp({30'h0, fbe_ans_valid, fbe_ans_ack}, {30'h0, 1'b1, e});
  endtask
  task automatic rx_pkt(input logic [7:0] b [$], input logic bad);
    foreach (b[i]) begin
      @(posedge mclk);
      rx_in <= '{1'b1, i == b.size() - 1, b[i]};
      rx_err <= bad && i == b.size() - 1;
    end
    @(posedge mclk);
    rx_in <= '{1'b0, 1'b0, ~b[b.size() - 1]};
    rx_err <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    chk(`OFS_STATUS, 32'h5);
    chk(`OFS_NAK_LIMIT, 32'h2);
    bus(1'b0, 8'h20, 32'h0);
    cmp({31'h0, err}, 32'h1);
    wr(`OFS_NODE_ID, 32'h5A);
    // short packet of 4 bytes in the upper half of page 1; stale source byte
    fill(11'h300, {8'hEE, 8'h33, 8'hFC});
    fill(11'h3FC, {8'h01, 8'h02, 8'h03, 8'h04});
    wr(`OFS_CMD, 32'h2B);
    chk(`OFS_STATUS, 32'h4);
    exp_q = {8'h5A, 8'h33, 8'hFC, 8'h01, 8'h02, 8'h03, 8'h04};
    tok(2000);
    cmp({24'h0, fbe_dest}, 32'h33);
    got_chk();
    chk(`OFS_STATUS, 32'h7);
    peek(11'h300, 8'h5A);
    wr(`OFS_MASK, 32'h1);
    irq_is(1'b1);
    wr(`OFS_MASK, 32'h0);
    irq_is(1'b0);
    // two refused enquiries reach the limit, then the host gives up
    enq_kind = pkt_seq_pkg::REPLY_NAK;
    wr(`OFS_CMD, 32'h2B);
    tok(50);
    cmp({31'h0, ok}, 32'h1);
    tok(50);
    chk(`OFS_STATUS, 32'hC);
    wr(`OFS_MASK, 32'h4);
    irq_is(1'b1);
    wr(`OFS_MASK, 32'h0);
    wr(`OFS_CMD, 32'h1);
    tok(50);
    chk(`OFS_STATUS, 32'hD);
    wr(`OFS_DIAG, 32'h1);
    enq_kind = pkt_seq_pkg::REPLY_NONE;
    wr(`OFS_CMD, 32'h2B);
    tok(50);
    chk(`OFS_STATUS, 32'h5);
    enq_kind = pkt_seq_pkg::REPLY_NOISE;
    wr(`OFS_CMD, 32'h2B);
    tok(30);
    cmp({31'h0, ok}, 32'h0);
    chk(`OFS_STATUS, 32'h4);
    wr(`OFS_CMD, 32'h1);
    tok(50);
    chk(`OFS_STATUS, 32'h5);
    // long packet of 257 bytes in page 2, the shortest long size
    enq_kind = pkt_seq_pkg::REPLY_ACK;
    wr(`OFS_CMD, 32'hD);
    exp_q = {8'h5A, 8'h44, 8'h00, 8'hFF};
    for (int i = 0; i < 257; i++) exp_q.push_back(8'(i * 7));
    fill(11'h400, {8'hEE, 8'h44, 8'h00, 8'hFF});
    fill(11'h4FF, exp_q[4:$]);
    wr(`OFS_CMD, 32'h13);
    tok(3000);
    got_chk();
    chk(`OFS_STATUS, 32'h7);
    // receive: a bad packet first, then a good one into the same page half
    wr(`OFS_CMD, 32'h24);
    chk(`OFS_STATUS, 32'h3);
    enq(1'b1);
    pk = {8'h11, 8'h5A, 8'hFD, 8'hA1, 8'hA2, 8'hA3};
    rx_pkt(pk, 1'b1);
    chk(`OFS_STATUS, 32'h3);
    rx_pkt(pk, 1'b0);
    chk(`OFS_STATUS, 32'h7);
    enq(1'b0);
    peek(11'h102, 8'hFD);
    peek(11'h1FD, 8'hA1);
    peek(11'h1FF, 8'hA3);
    wr(`OFS_MASK, 32'h2);
    irq_is(1'b1);
    wrap_up();
  end
  // watchdog well beyond a worst-case token round trip of this run
  initial begin
    #500000;
    fail_count++;
    wrap_up();
  end
endmodule
